// file: rtl/epc_compare.sv
// Operation
// - single mode completes when position hits target
// - rising step sequence, done past last target
// - falling step sequence, done past last target
// - current target keeps last used value
// - table mode walks entries, done after last
// - table length up to 100 entries; the APB table window 0x80..0xFF loads only entries 0..31
// - table done flag held, not pulsed
// - count of completed comparisons is presented
// - hardware output driven on match when enabled
// - interrupt number 1..16, zero means none
// - match with assigned number requests interrupt
// - scaling update loads four scaling values
// - mode update loads mode and rotary period
// - mode update loads soft limit and limits
// - output held for width in time or pulses
// - output reacts within five microseconds
// - parameters captured at enable rising edge
//
// Purpose: position compare unit for a local encoder axis
// Assumes: position is a synchronous signed count; edge_pulse marks each encoder pulse
// Notes: APB slave, zero wait state; CTRL bits: 0 enable,2:1 mode,3 hw out en,8:4 irq no,9 hold unit,
//        16 scale update,17 axis mode update (update bits self-clear)
`timescale 1ns/1ns
module epc_compare
  import epc_pkg::*;
#(
  parameter int TABLE_DEPTH = TABLE_MAX
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // encoder side
  input wire logic [31:0] axis_position,
  input wire logic edge_pulse,
  // outputs
  output logic hw_match_out,
  output logic match_done,
  output logic [6:0] match_count,
  output logic irq_req,
  output logic [4:0] irq_num,
  output epc_scale_s axis_scale,
  output epc_axmode_s axis_mode
);
  typedef enum logic [3:0] {
    EPC_IDLE = 4'b0001,
    EPC_RUN = 4'b0010,
    EPC_DONE = 4'b0100,
    EPC_BAD = 4'b1000
  } epc_state_e;

  epc_state_e st_q;
  logic [31:0] ctrl_q, target_q, first_q, last_q, step_q, hold_q;
  logic [6:0] tlen_q, tstart_q;
  logic [31:0] step_cap_q, last_cap_q;
  logic [6:0] tlen_cap_q;
  logic [31:0] table_q [TABLE_DEPTH];
  epc_scale_s scale_q;
  epc_axmode_s axm_q;
  logic en_q;
  logic [1:0] mode_q;
  logic out_en_q, unit_pulse_q;
  logic [4:0] irq_sel_q;
  logic [15:0] width_q;
  logic [31:0] cur_q;
  logic [6:0] idx_q, cnt_q;
  logic eq_seen_q;
  logic [15:0] hold_cnt_q;
  logic [$clog2(HOLD_UNIT_CYC+1)-1:0] tick_q;
  logic wr, rd, eq, hit, tick;
  logic [31:0] next_step;
  logic step_over;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign eq = (axis_position == cur_q);
  assign hit = (st_q == EPC_RUN) && eq && !eq_seen_q;
  assign next_step = cur_q + step_cap_q;
  // sequence ends once the next target leaves the range
  assign step_over = $signed(step_cap_q) > 0 ? ($signed(next_step) > $signed(last_cap_q))
                                             : ($signed(next_step) < $signed(last_cap_q));
  assign tick = (tick_q == '0);

  // apb register writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 32'h0;
      target_q <= 32'h0;
      first_q <= 32'h0;
      last_q <= 32'h0;
      step_q <= 32'h0;
      hold_q <= 32'h0;
      tlen_q <= 7'h0;
      tstart_q <= 7'h0;
    end else begin
      ctrl_q[17:16] <= 2'h0;
      if (wr) begin
        unique case (paddr)
          A_CTRL: ctrl_q <= pwdata;
          A_TARGET: target_q <= pwdata;
          A_FIRST: first_q <= pwdata;
          A_LAST: last_q <= pwdata;
          A_STEP: step_q <= pwdata;
          A_HOLD: hold_q <= pwdata;
          A_TLEN: tlen_q <= (pwdata > TABLE_DEPTH) ? 7'(TABLE_DEPTH) : pwdata[6:0];
          A_TSTART: tstart_q <= pwdata[6:0];
          default: ;
        endcase
      end
    end
  end

  // table memory, written by the controller
  always_ff @(posedge sys_clk) begin
    if (wr && paddr >= A_TBL && ((paddr - A_TBL) >> 2) < TABLE_DEPTH) begin
      table_q[7'((paddr - A_TBL) >> 2)] <= pwdata;
    end
  end

  // axis configuration updates; caller must have stopped other axis functions first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scale_q <= '0;
      axm_q <= '0;
    end else begin
      if (wr) begin
        unique case (paddr)
          A_PPR: scale_q.pulses_per_rev <= pwdata;
          A_DPR: scale_q.distance_per_rev <= pwdata;
          A_GNUM: scale_q.gear_num <= pwdata;
          A_GDEN: scale_q.gear_den <= pwdata;
          A_AXMODE: begin
            axm_q.linear_or_rotary_select <= pwdata[0];
            axm_q.soft_limit_on <= pwdata[1];
          end
          A_PLIM: axm_q.pos_limit <= pwdata;
          A_NLIM: axm_q.neg_limit <= pwdata;
          A_ROTP: axm_q.rotary_period <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // staged values become live only on update strobes, so partial writes never show
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      axis_scale <= '0;
      axis_mode <= '0;
    end else begin
      if (ctrl_q[16] && !en_q) axis_scale <= scale_q;
      if (ctrl_q[17] && !en_q) axis_mode <= axm_q;
    end
  end

  // read mux, reads answer in the access phase with no wait
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (rd) begin
      unique case (paddr)
        A_CTRL: prdata <= ctrl_q;
        A_STATUS: prdata <= {22'h0, cnt_q, match_done, en_q, hw_match_out};
        A_TARGET: prdata <= target_q;
        A_FIRST: prdata <= first_q;
        A_LAST: prdata <= last_q;
        A_STEP: prdata <= step_q;
        A_TLEN: prdata <= {25'h0, tlen_q};
        A_TSTART: prdata <= {25'h0, tstart_q};
        A_HOLD: prdata <= hold_q;
        A_CUR: prdata <= cur_q;
        default: prdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > A_ROTP) && (paddr < A_TBL);
    end
  end

  // parameter capture on enable rise only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
      mode_q <= MODE_SINGLE;
      out_en_q <= 1'b0;
      irq_sel_q <= 5'h0;
      unit_pulse_q <= 1'b0;
      width_q <= 16'h0;
      step_cap_q <= 32'h0;
      last_cap_q <= 32'h0;
      tlen_cap_q <= 7'h0;
    end else begin
      en_q <= ctrl_q[0];
      if (ctrl_q[0] && !en_q) begin
        mode_q <= ctrl_q[2:1];
        out_en_q <= ctrl_q[3];
        irq_sel_q <= (ctrl_q[8:4] > 5'h10) ? 5'h0 : ctrl_q[8:4];
        unit_pulse_q <= ctrl_q[9];
        width_q <= hold_q[15:0];
        // live sequence limits would let a running walk change course
        step_cap_q <= step_q;
        last_cap_q <= last_q;
        tlen_cap_q <= tlen_q;
      end
    end
  end

  // compare sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= EPC_IDLE;
      cur_q <= 32'h0;
      idx_q <= 7'h0;
      cnt_q <= 7'h0;
      eq_seen_q <= 1'b0;
    end else begin
      eq_seen_q <= (st_q == EPC_RUN) && eq;
      unique case (st_q)
        EPC_IDLE: begin
          if (ctrl_q[0] && !en_q) begin
            st_q <= EPC_RUN;
            cnt_q <= 7'h0;
            idx_q <= tstart_q;
            unique case (ctrl_q[2:1])
              MODE_STEP: cur_q <= first_q;
              MODE_TABLE: cur_q <= table_q[tstart_q];
              default: cur_q <= target_q;
            endcase
          end
        end
        EPC_RUN: begin
          if (!ctrl_q[0]) begin
            st_q <= EPC_IDLE;
            cnt_q <= 7'h0;
          end else if (hit) begin
            cnt_q <= cnt_q + 7'h1;
            unique case (mode_q)
              MODE_STEP: begin
                if (step_cap_q == 32'h0 || step_over) st_q <= EPC_DONE;
                else cur_q <= next_step;
              end
              MODE_TABLE: begin
                if (cnt_q + 7'h1 >= tlen_cap_q || idx_q + 7'h1 >= 7'(TABLE_DEPTH)) begin
                  st_q <= EPC_DONE;
                end else begin
                  idx_q <= idx_q + 7'h1;
                  cur_q <= table_q[idx_q + 7'h1];
                end
              end
              default: st_q <= EPC_DONE;
            endcase
          end
        end
        EPC_DONE: begin
          if (!ctrl_q[0]) begin
            st_q <= EPC_IDLE;
            cnt_q <= 7'h0;
          end
        end
        default: st_q <= EPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      match_done <= 1'b0;
      match_count <= 7'h0;
    end else begin
      match_done <= (st_q == EPC_DONE) && ctrl_q[0];
      match_count <= cnt_q;
    end
  end

  // interrupt request, one pulse per match
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_req <= 1'b0;
      irq_num <= 5'h0;
    end else begin
      irq_req <= hit && (irq_sel_q != 5'h0);
      irq_num <= irq_sel_q;
    end
  end

  // hold timer; counts 0.1 ms ticks or encoder pulses
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_q <= '0;
    end else begin
      tick_q <= (tick || hit) ? ($bits(tick_q))'(HOLD_UNIT_CYC - 1) : tick_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hw_match_out <= 1'b0;
      hold_cnt_q <= 16'h0;
    end else if (!ctrl_q[0]) begin
      hw_match_out <= 1'b0;
      hold_cnt_q <= 16'h0;
    end else if (hit && out_en_q) begin
      hw_match_out <= 1'b1;
      hold_cnt_q <= width_q;
    end else if (hw_match_out && (unit_pulse_q ? edge_pulse : tick)) begin
      if (hold_cnt_q <= 16'h1) hw_match_out <= 1'b0;
      hold_cnt_q <= hold_cnt_q - 16'h1;
    end
  end

  // checks
  chk_out_fast: assert property (@(posedge sys_clk) disable iff (rst)
    (hit && out_en_q && ctrl_q[0]) |=> hw_match_out) else $error("hw output late");

  chk_irq_none: assert property (@(posedge sys_clk) disable iff (rst)
    (irq_sel_q == 5'h0) |=> !irq_req) else $error("irq with number zero");

  chk_irq_hit: assert property (@(posedge sys_clk) disable iff (rst)
    (hit && irq_sel_q != 5'h0) |=> irq_req) else $error("irq missed");

  chk_no_rehit: assert property (@(posedge sys_clk) disable iff (rst)
    hit |=> !hit) else $error("held equality counted twice");

  chk_done_held: assert property (@(posedge sys_clk) disable iff (rst)
    (match_done && ctrl_q[0] && $stable(ctrl_q[0])) |=> match_done) else $error("done dropped");

  chk_off_clear: assert property (@(posedge sys_clk) disable iff (rst)
    !ctrl_q[0] |=> ##1 (!match_done && match_count == 7'h0)) else $error("disable did not clear");

  chk_count_step: assert property (@(posedge sys_clk) disable iff (rst)
    (hit && ctrl_q[0]) |=> cnt_q == $past(cnt_q) + 7'h1) else $error("count not advanced");

  sequence s_step_hit;
    hit && mode_q == MODE_STEP && !step_over && step_cap_q != 32'h0 && ctrl_q[0];
  endsequence
  chk_step_adv: assert property (@(posedge sys_clk) disable iff (rst)
    s_step_hit |=> cur_q == $past(next_step)) else $error("step target not advanced");

  chk_keep_last: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == EPC_DONE) |=> $stable(cur_q)) else $error("last target changed");

  chk_capture: assert property (@(posedge sys_clk) disable iff (rst)
    (en_q && ctrl_q[0]) |=> $stable(mode_q)) else $error("mode changed while held");
endmodule

// file: rtl/epc_pkg.sv
// Purpose: shared constants and carriers for the encoder position compare block
// Assumes: 32-bit signed positions, one 100 MHz clock
// Notes: register offsets are byte addresses on APB
package epc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned HOLD_UNIT_NS = 100_000;
  localparam int unsigned HOLD_UNIT_CYC = (HOLD_UNIT_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned TABLE_MAX = 100;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_STEP = 2'h1;
  localparam logic [1:0] MODE_TABLE = 2'h2;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_TARGET = 8'h08;
  localparam logic [7:0] A_FIRST = 8'h0C;
  localparam logic [7:0] A_LAST = 8'h10;
  localparam logic [7:0] A_STEP = 8'h14;
  localparam logic [7:0] A_TLEN = 8'h18;
  localparam logic [7:0] A_TSTART = 8'h1C;
  localparam logic [7:0] A_HOLD = 8'h20;
  localparam logic [7:0] A_CUR = 8'h24;
  localparam logic [7:0] A_PPR = 8'h28;
  localparam logic [7:0] A_DPR = 8'h2C;
  localparam logic [7:0] A_GNUM = 8'h30;
  localparam logic [7:0] A_GDEN = 8'h34;
  localparam logic [7:0] A_AXMODE = 8'h38;
  localparam logic [7:0] A_PLIM = 8'h3C;
  localparam logic [7:0] A_NLIM = 8'h40;
  localparam logic [7:0] A_ROTP = 8'h44;
  localparam logic [7:0] A_TBL = 8'h80;
  localparam logic [7:0] A_TBL_END = 8'hFF;
  typedef struct packed {
    logic [31:0] pulses_per_rev;
    logic [31:0] distance_per_rev;
    logic [31:0] gear_num;
    logic [31:0] gear_den;
  } epc_scale_s;
  typedef struct packed {
    logic linear_or_rotary_select;
    logic soft_limit_on;
    logic [31:0] pos_limit;
    logic [31:0] neg_limit;
    logic [31:0] rotary_period;
  } epc_axmode_s;
endpackage

// file: tb/epc_encoder_model.sv
// Purpose: encoder side model, walks the axis position toward a goal
// Assumes: one count step per move, edge pulse with every step
// Notes: slow mode moves once every four cycles to stretch match spacing
`timescale 1ns/1ns
module epc_encoder_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // command from bench
  input wire logic [31:0] goal,
  input wire logic slow,
  // encoder outputs
  output logic [31:0] axis_position,
  output logic edge_pulse
);
  logic [31:0] pos_q;
  logic [1:0] div_q;
  logic pulse_q;
  assign axis_position = pos_q;
  assign edge_pulse = pulse_q;
  // one step per move, so every target on the way is seen as equal
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pos_q <= 32'h0;
      div_q <= 2'h0;
      pulse_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      pulse_q <= 1'b0;
      if ((!slow || div_q == 2'h0) && pos_q != goal) begin
        pos_q <= ($signed(pos_q) < $signed(goal)) ? pos_q + 32'h1 : pos_q - 32'h1;
        pulse_q <= 1'b1;
      end
    end
  end
endmodule

// file: tb/encoder_position_compare_test.sv
// Purpose: self-checking bench for the position compare block
// Assumes: APB master waits for pready, positions stepped by the encoder model
// Notes: sampling done on the falling edge so registered outputs are settled
`timescale 1ns/1ns
module encoder_position_compare_test;
  import epc_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, edge_pulse, slow;
  logic hw_match_out, match_done, irq_req;
  logic hw_prev = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, axis_position, goal;
  logic [6:0] match_count;
  logic [4:0] irq_num;
  epc_scale_s axis_scale;
  epc_axmode_s axis_mode;
  int errors = 0, checks_done = 0, base_irq, base_hw;
  int irq_cnt = 0, hw_cnt = 0;

  epc_compare dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .axis_position(axis_position), .edge_pulse(edge_pulse), .hw_match_out(hw_match_out),
    .match_done(match_done), .match_count(match_count), .irq_req(irq_req), .irq_num(irq_num),
    .axis_scale(axis_scale), .axis_mode(axis_mode));
  epc_encoder_model enc_u (.sys_clk(sys_clk), .rst(rst), .goal(goal), .slow(slow),
    .axis_position(axis_position), .edge_pulse(edge_pulse));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // pulse counters; scenarios compare differences, never reset them
  always @(posedge sys_clk) begin
    if (irq_req === 1'b1) irq_cnt = irq_cnt + 1;
    if (hw_match_out === 1'b1 && hw_prev !== 1'b1) hw_cnt = hw_cnt + 1;
    hw_prev = hw_match_out;
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    // pready and read data are taken at the edge that completes the access
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, pready, 1'b1);
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic move(input logic [31:0] g, input logic s);
    @(posedge sys_clk);
    goal <= g;
    slow <= s;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (match_done !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    chk({31'h0, match_done}, 32'h1);
    if (n >= 2000) tally_and_finish();
  endtask
  // disable must drop completion, count and any output still held
  task automatic stop;
    wr(A_CTRL, 32'h0);
    // outputs clear one edge after the write, the count one edge later
    repeat (3) @(negedge sys_clk);
    chk({24'h0, match_done, match_count}, 32'h0);
    chk({31'h0, hw_match_out}, 32'h0);
  endtask

  initial begin
    {psel, penable, pwrite, slow} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    goal = 32'h0;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    begin : unmapped
      logic [31:0] r;
      logic e;
      apb(1'b0, 8'h48, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
    end
    // configuration updates, issued while compare is idle
    wr(A_PPR, 32'h2710);
    wr(A_DPR, 32'h1);
    wr(A_GNUM, 32'h1);
    wr(A_GDEN, 32'h2);
    wr(A_CTRL, 32'h10000);
    repeat (2) @(negedge sys_clk);
    chk(axis_scale.pulses_per_rev, 32'h2710);
    chk({axis_scale.distance_per_rev[15:0], axis_scale.gear_num[7:0], axis_scale.gear_den[7:0]}, 32'h10102);
    wr(A_AXMODE, 32'h3);
    wr(A_PLIM, 32'h3E8);
    wr(A_NLIM, 32'hFFFFFF9C);
    wr(A_ROTP, 32'h168);
    wr(A_CTRL, 32'h20000);
    repeat (2) @(negedge sys_clk);
    chk({30'h0, axis_mode.linear_or_rotary_select, axis_mode.soft_limit_on}, 32'h3);
    chk(axis_mode.pos_limit ^ axis_mode.neg_limit, 32'hFFFFFC74);
    chk(axis_mode.rotary_period, 32'h168);
    // single target, hold counted in encoder pulses, irq 3
    base_irq = irq_cnt;
    base_hw = hw_cnt;
    wr(A_TARGET, 32'h5);
    wr(A_HOLD, 32'h3);
    wr(A_CTRL, 32'h239);
    wr(A_TARGET, 32'h63);
    move(32'h5, 1'b0);
    wait_done();
    repeat (20) @(negedge sys_clk);
    chk({25'h0, match_count}, 32'h1);
    chk(irq_cnt - base_irq, 32'h1);
    chk({27'h0, irq_num}, 32'h3);
    chk(hw_cnt - base_hw, 32'h1);
    chk({31'h0, hw_match_out}, 32'h1);
    // two encoder pulses leave the three-pulse hold running, the third ends it
    move(32'h7, 1'b0);
    repeat (6) @(negedge sys_clk);
    chk({31'h0, hw_match_out}, 32'h1);
    move(32'h8, 1'b0);
    repeat (4) @(negedge sys_clk);
    chk({31'h0, hw_match_out}, 32'h0);
    stop();
    // rising stepped sequence, no irq assigned
    base_irq = irq_cnt;
    move(32'h0, 1'b0);
    wr(A_FIRST, 32'h2);
    wr(A_LAST, 32'hA);
    wr(A_STEP, 32'h4);
    wr(A_CTRL, 32'h3);
    move(32'h14, 1'b1);
    wait_done();
    chk({25'h0, match_count}, 32'h3);
    rd(A_CUR, 32'hA);
    chk(irq_cnt - base_irq, 32'h0);
    stop();
    // falling stepped sequence with a negative step
    wr(A_FIRST, 32'hA);
    wr(A_LAST, 32'h2);
    wr(A_STEP, 32'hFFFFFFFC);
    wr(A_CTRL, 32'h3);
    move(32'h0, 1'b0);
    wait_done();
    chk({25'h0, match_count}, 32'h3);
    rd(A_CUR, 32'h2);
    stop();
    // table walk from element 1, three entries, irq 16, hw out in 0.1 ms units
    base_irq = irq_cnt;
    base_hw = hw_cnt;
    wr(A_TBL, 32'h3);
    wr(A_TBL + 8'h04, 32'h7);
    wr(A_TBL + 8'h08, 32'h9);
    wr(A_TBL + 8'h0C, 32'hC);
    wr(A_TSTART, 32'h1);
    wr(A_TLEN, 32'hC8);
    rd(A_TLEN, 32'h64);
    wr(A_TLEN, 32'h3);
    wr(A_CTRL, 32'h10D);
    move(32'hF, 1'b1);
    wait_done();
    chk({25'h0, match_count}, 32'h3);
    chk(irq_cnt - base_irq, 32'h3);
    chk({27'h0, irq_num}, 32'h10);
    repeat (30) @(negedge sys_clk);
    chk({31'h0, match_done}, 32'h1);
    chk(hw_cnt - base_hw, 32'h1);
    chk({31'h0, hw_match_out}, 32'h1);
    stop();
    tally_and_finish();
  end
endmodule
